//--- hdl/serial_pkg.sv
/*
  constants for the serial transceiver: register offsets, field positions,
  reset values and frame timing.
  assumes a 32-bit ahb-lite register bus, one register per aligned word.
*/
package serial_pkg;
  localparam logic [7:0] off_data = 8'h00;
  localparam logic [7:0] off_status = 8'h04;
  localparam logic [7:0] off_ctrl = 8'h08;
  localparam logic [7:0] off_format = 8'h0c;
  localparam logic [7:0] off_div_low = 8'h10;
  localparam logic [7:0] off_div_high = 8'h14;
  // status bits
  localparam int st_rx_valid = 0;
  localparam int st_tx_empty = 1;
  localparam int st_tx_idle = 2;
  localparam int st_frame_err = 3;
  localparam int st_overrun = 4;
  localparam int st_ninth = 5;
  localparam int st_parity_err = 6;
  // control bits
  localparam int ct_rx_en = 0;
  localparam int ct_tx_en = 1;
  localparam int ct_double = 2;
  localparam int ct_ninth_tx = 3;
  localparam int ct_clk_dir = 4;
  // format bits
  localparam int fm_size_lo = 0;
  localparam int fm_parity_lo = 3;
  localparam int fm_stop = 5;
  localparam int fm_sync = 6;
  localparam int fm_polarity = 7;
  localparam logic [2:0] size_nine = 3'h7;
  localparam logic [1:0] par_off = 2'h0;
  localparam logic [1:0] par_even = 2'h2;
  localparam logic [1:0] par_odd = 2'h3;
  localparam logic [7:0] format_reset = 8'h06;
  localparam logic [4:0] samples_normal = 5'h10;
  localparam logic [4:0] samples_double = 5'h08;
  localparam logic [4:0] samples_sync = 5'h02;
  localparam int fifo_depth = 2;
  localparam logic [31:0] bus_unmapped = 32'h00000000;
endpackage

//--- hdl/baud_counter.sv
/*
  baud rate down-counter with reload on zero or on a low divisor write.
  assumes a single system clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
module baud_counter #(
  parameter int width = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [width-1:0] divisor,
  input wire logic reload,
  output logic tick
);
  typedef struct packed {
    logic [width-1:0] count;
    logic tick;
  } state_t;
  state_t s_r;
  state_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (reload)
    begin
      s_nxt.count = divisor;
    end
    else if (s_r.count == '0)
    begin
      s_nxt.count = divisor;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.count = s_r.count - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

//--- hdl/rx_fifo.sv
/*
  two-entry circular receive buffer; data plus per-character status.
  read data come from a register; assumes push is never made when full.
*/
`timescale 1ns/10ps
module rx_fifo #(
  parameter int width = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic push,
  input wire logic [width-1:0] push_data,
  input wire logic pop,
  output logic [width-1:0] head,
  output logic full,
  output logic empty
);
  typedef struct packed {
    logic [1:0][width-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic [width-1:0] head;
  } state_t;
  state_t s_r;
  state_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (push && s_r.cnt != 2'h2)
    begin
      s_nxt.mem[s_r.wp] = push_data;
      s_nxt.wp = ~s_r.wp;
    end
    if (pop && s_r.cnt != 2'h0)
    begin
      s_nxt.rp = ~s_r.rp;
    end
    s_nxt.cnt = s_r.cnt + {1'b0, push && s_r.cnt != 2'h2}
      - {1'b0, pop && s_r.cnt != 2'h0};
    s_nxt.head = s_nxt.mem[s_nxt.rp];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign head = s_r.head;
  assign full = s_r.cnt == 2'h2;
  assign empty = s_r.cnt == 2'h0;
endmodule

//--- hdl/serial_port.sv
/*
  serial transceiver: baud generation, async/sync clocking, frame
  transmit and receive, two-level receive buffer, ahb-lite registers.
  assumes rxd and the transfer clock pin are asynchronous to hclk.
*/
// Chosen here: the placing of the registers and the AHB-Lite register port.
// How it works
// - two receive buffers form a circular fifo; data read pops one.
// - frame error, overrun and ninth bit travel with each character.
// - with both buffers full, a finished character waits in rx_done.
// - normal, double-speed async and master, slave sync; one mode bit.
// - in sync mode clock direction picks master drive or slave sample.
// - down-counter reloads on zero or low divisor write, ticks at zero.
// - transmitter divides ticks by 16, 8 or 2; receiver likewise.
// - divisor is 12 bits from high and low registers.
// - double speed acts only in async mode; software keeps it zero.
// - double speed receiver uses 8 samples per bit, not 16.
// - slave clock passes a synchroniser and edge detector.
// - sync data sampled on edge opposite to the changing edge.
// - polarity zero: change on rising, sample falling; one swaps.
// - one start, 5 to 9 data, none/even/odd parity, 1 or 2 stops.
// - start, data lsb first, parity if on, then stop bits.
// - after stop bits send next frame at once or idle high.
// - transmitter and receiver share one frame format setting.
// - size field sets bits, parity field parity, stop select stops.
// - receiver checks only the first stop bit for frame error.
// - parity is xor of data bits, inverted for odd.
// - size 7 selects nine bits; ninth comes from a control bit.
// - shifter loads buffer when idle or right after last stop bit.
`timescale 1ns/10ps
module serial_port #(
  parameter int div_width = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd,
  output logic txd,
  input wire logic transfer_clock_pin_in,
  output logic transfer_clock_pin_out,
  output logic transfer_clock_pin_oe
);
  typedef enum logic [1:0] {
    tx_idle = 2'b00,
    tx_start = 2'b01,
    tx_bits = 2'b10
  } tx_state_t;
  typedef enum logic [1:0] {
    rx_idle = 2'b00,
    rx_start = 2'b01,
    rx_bits = 2'b10,
    rx_hold = 2'b11
  } rx_state_t;
  typedef struct packed {
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [7:0] ctrl;
    logic [7:0] format;
    logic [div_width-1:0] divisor;
    logic [8:0] tx_buf;
    logic tx_full;
    tx_state_t tx_st;
    logic [12:0] tx_sh;
    logic [3:0] tx_left;
    logic [4:0] tx_ph;
    rx_state_t rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [4:0] rx_ph;
    logic rx_par;
    logic [11:0] rx_done;
    logic [2:0] rxd_s;
    logic [2:0] xck_s;
    logic xck_o;
    logic [4:0] xck_ph;
  } state_t;
  state_t s_r;
  state_t s_nxt;

  logic tick;
  logic reload;
  logic push;
  logic pop;
  logic [11:0] head;
  logic fifo_full;
  logic fifo_empty;
  logic sync;
  logic slave;
  logic [4:0] spb;
  logic [3:0] nbits;
  logic [1:0] pmode;
  logic clk_en;
  logic edge_chg;
  logic edge_smp;
  logic rx_in;
  logic [8:0] dmask;
  logic xck_rise;
  logic xck_fall;
  logic bus_req;

  baud_counter #(.width(div_width)) u_baud (
    .hclk(hclk),
    .hresetn(hresetn),
    .divisor(s_r.divisor),
    .reload(reload),
    .tick(tick)
  );

  rx_fifo #(.width(12)) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .push(push),
    .push_data(s_r.rx_done),
    .pop(pop),
    .head(head),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  assign bus_req = hsel && hready && htrans[1];
  assign sync = s_r.format[serial_pkg::fm_sync];
  assign slave = sync && !s_r.ctrl[serial_pkg::ct_clk_dir];
  assign pmode = s_r.format[serial_pkg::fm_parity_lo +: 2];
  // one format register feeds both directions
  assign nbits = (s_r.format[2:0] == serial_pkg::size_nine) ? 4'h9
    : {1'b0, s_r.format[2:0]} + 4'h5;
  assign dmask = 9'h1ff >> (4'h9 - nbits);
  assign spb = sync ? serial_pkg::samples_sync
    : (s_r.ctrl[serial_pkg::ct_double] ? serial_pkg::samples_double
    : serial_pkg::samples_normal);
  // second stage and third form the edge detector
  assign xck_rise = s_r.xck_s[1] && !s_r.xck_s[2];
  assign xck_fall = !s_r.xck_s[1] && s_r.xck_s[2];
  // change edge and sample edge are opposite
  assign edge_chg = s_r.format[serial_pkg::fm_polarity] ? xck_fall : xck_rise;
  assign edge_smp = s_r.format[serial_pkg::fm_polarity] ? xck_rise : xck_fall;
  assign clk_en = slave ? 1'b0 : tick;
  assign rx_in = s_r.rxd_s[1];
  assign reload = s_r.wr_pend && s_r.addr == serial_pkg::off_div_low;
  assign pop = s_r.rd_pend
    && s_r.addr == serial_pkg::off_data;
  assign push = s_r.rx_st == rx_hold && !fifo_full;

  always_comb
  begin
    logic tx_step;
    logic rx_step;
    logic par;
    tx_step = 1'b0;
    rx_step = 1'b0;
    par = 1'b0;
    s_nxt = s_r;
    s_nxt.wr_pend = bus_req && hwrite;
    s_nxt.rd_pend = bus_req && !hwrite;
    if (bus_req)
    begin
      s_nxt.addr = haddr[7:0];
    end
    s_nxt.rxd_s = {s_r.rxd_s[1:0], rxd};
    s_nxt.xck_s = {s_r.xck_s[1:0], transfer_clock_pin_in};
    if (s_r.wr_pend)
    begin
      case (s_r.addr)
        serial_pkg::off_data:
        begin
          if (!s_r.tx_full)
          begin
            s_nxt.tx_buf = {s_r.ctrl[serial_pkg::ct_ninth_tx],
              hwdata[7:0]};
            s_nxt.tx_full = 1'b1;
          end
        end
        serial_pkg::off_ctrl: s_nxt.ctrl = hwdata[7:0];
        serial_pkg::off_format: s_nxt.format = hwdata[7:0];
        serial_pkg::off_div_low: s_nxt.divisor[7:0] = hwdata[7:0];
        serial_pkg::off_div_high:
          s_nxt.divisor[div_width-1:8] = hwdata[div_width-9:0];
        default: ;
      endcase
    end
    // master clock output toggles every baud tick: divide by 2
    if (sync && !slave && tick)
    begin
      s_nxt.xck_o = ~s_r.xck_o;
    end
    // timing: slave sync uses pin edges, master sync baud ticks, async phase counters
    if (sync)
    begin
      if (slave)
      begin
        tx_step = edge_chg;
        rx_step = edge_smp;
      end
      else
      begin
        tx_step = tick && !s_r.xck_o; // next pin edge is the change edge
        rx_step = tick && s_r.xck_o;
      end
    end
    else if (clk_en)
    begin
      s_nxt.tx_ph = (s_r.tx_ph == spb - 5'h1) ? 5'h0 : s_r.tx_ph + 5'h1;
      tx_step = s_r.tx_ph == spb - 5'h1;
    end
    // transmitter
    case (s_r.tx_st)
      tx_idle:
      begin
        s_nxt.tx_ph = 5'h0;
        if (s_r.tx_full && s_r.ctrl[serial_pkg::ct_tx_en])
        begin
          s_nxt.tx_st = tx_start;
        end
      end
      tx_start:
      begin
        par = ^(s_r.tx_buf & dmask) ^ pmode[0];
        s_nxt.tx_ph = 5'h0;
        // start, data lsb first, parity, stops (line high)
        s_nxt.tx_sh = 13'h1fff;
        s_nxt.tx_sh[0] = 1'b0;
        s_nxt.tx_sh[9:1] = (s_r.tx_buf & dmask)
          | (9'h1ff & ~dmask);
        if (pmode[1])
        begin
          s_nxt.tx_sh[nbits+4'h1] = par;
        end
        s_nxt.tx_left = 4'h2 + nbits + {3'h0, pmode[1]}
          + {3'h0, s_r.format[serial_pkg::fm_stop]};
        s_nxt.tx_full = 1'b0;
        s_nxt.tx_st = tx_bits;
      end
      tx_bits:
      begin
        if (tx_step)
        begin
          s_nxt.tx_sh = {1'b1, s_r.tx_sh[12:1]};
          s_nxt.tx_left = s_r.tx_left - 4'h1;
          if (s_r.tx_left == 4'h1)
          begin
            // next frame at once, else idle high
            s_nxt.tx_st = s_r.tx_full ? tx_start : tx_idle;
          end
        end
      end
      default: s_nxt.tx_st = tx_idle;
    endcase
    // receiver
    if (!sync && clk_en && s_r.rx_st != rx_idle)
    begin
      s_nxt.rx_ph = (s_r.rx_ph == spb - 5'h1) ? 5'h0 : s_r.rx_ph + 5'h1;
      rx_step = s_r.rx_ph == (spb >> 1) - 5'h1;
    end
    case (s_r.rx_st)
      rx_idle:
      begin
        s_nxt.rx_ph = 5'h0;
        s_nxt.rx_cnt = 4'h0;
        s_nxt.rx_par = pmode[0];
        if (s_r.ctrl[serial_pkg::ct_rx_en])
        begin
          if (sync ? (rx_step && !rx_in) : (!rx_in && s_r.rxd_s[2]))
          begin
            s_nxt.rx_st = sync ? rx_bits : rx_start;
          end
        end
      end
      rx_start:
      begin
        if (rx_step)
        begin
          s_nxt.rx_st = rx_in ? rx_idle : rx_bits;
        end
      end
      rx_bits:
      begin
        if (rx_step)
        begin
          s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
          if (s_r.rx_cnt < nbits)
          begin
            s_nxt.rx_sh = {rx_in, s_r.rx_sh[8:1]};
            s_nxt.rx_par = s_r.rx_par ^ rx_in;
          end
          else if (pmode[1] && s_r.rx_cnt == nbits)
          begin
            s_nxt.rx_par = s_r.rx_par ^ rx_in;
          end
          else
          begin
            // only the first stop bit is checked
            s_nxt.rx_done = {pmode[1] && s_r.rx_par, fifo_full,
              !rx_in, s_r.rx_sh >> (4'h9 - nbits)};
            s_nxt.rx_st = rx_hold;
          end
        end
      end
      rx_hold:
      begin
        // wait here while both buffers are full; a start meanwhile sets overrun
        if (!fifo_full)
        begin
          s_nxt.rx_st = rx_idle;
        end
        else if (!rx_in && s_r.rxd_s[2])
        begin
          s_nxt.rx_done[serial_pkg::st_overrun + 6] = 1'b1;
          s_nxt.rx_st = rx_hold;
        end
      end
      default: s_nxt.rx_st = rx_idle;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_r <= '0;
      s_r.format <= serial_pkg::format_reset;
      s_r.tx_sh <= 13'h1fff;
      s_r.rxd_s <= 3'h7;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // register read data, zero for unmapped
  always_comb
  begin
    case (s_r.addr)
      serial_pkg::off_data: hrdata = {23'h0, head[8:0]};
      serial_pkg::off_status: hrdata = {25'h0, head[11], head[8],
        head[10], head[9], s_r.tx_st == tx_idle, !s_r.tx_full,
        !fifo_empty};
      serial_pkg::off_ctrl: hrdata = {24'h0, s_r.ctrl};
      serial_pkg::off_format: hrdata = {24'h0, s_r.format};
      serial_pkg::off_div_low: hrdata = {24'h0, s_r.divisor[7:0]};
      serial_pkg::off_div_high: hrdata = {28'h0, s_r.divisor[11:8]};
      default: hrdata = serial_pkg::bus_unmapped;
    endcase
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign txd = s_r.tx_sh[0];
  assign transfer_clock_pin_out = s_r.xck_o
    ^ s_r.format[serial_pkg::fm_polarity];
  assign transfer_clock_pin_oe = sync && !slave;
endmodule

//--- testbench/serial_port_monitor.sv
/*
  checker for serial_port: bus answer, readback, txd bit timing.
  assumes a bind to serial_port; sees its ports only.
*/
`timescale 1ns/10ps
module serial_port_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic txd,
  input wire logic transfer_clock_pin_oe
);
  logic v_r;
  logic w_r;
  logic [7:0] a_r;
  logic [7:0] fmt_r;
  logic [7:0] ctl_r;
  logic [11:0] div_r;
  logic rd;
  logic wr;
  logic a0;
  assign rd = v_r & ~w_r;
  assign wr = v_r & w_r;
  assign a0 = ~fmt_r[serial_pkg::fm_sync] & (div_r == 12'h000);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      v_r <= 1'b0;
      w_r <= 1'b0;
      a_r <= 8'h00;
      fmt_r <= serial_pkg::format_reset;
      ctl_r <= 8'h00;
      div_r <= 12'h000;
    end
    else
    begin
      if (hready)
      begin
        v_r <= hsel & htrans[1];
        w_r <= hwrite;
        a_r <= haddr[7:0];
      end
      if (wr && a_r == serial_pkg::off_format)
        fmt_r <= hwdata[7:0];
      if (wr && a_r == serial_pkg::off_ctrl)
        ctl_r <= hwdata[7:0];
      if (wr && a_r == serial_pkg::off_div_low)
        div_r[7:0] <= hwdata[7:0];
      if (wr && a_r == serial_pkg::off_div_high)
        div_r[11:8] <= hwdata[3:0];
    end
  default clocking mon_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  chk_zero_wait:
    assert property (hreadyout && !hresp) else $error("bus answer bad");
  chk_format_read:
    assert property (rd && a_r == serial_pkg::off_format |->
      hrdata[7:0] == fmt_r) else $error("format readback wrong");
  chk_divisor_read:
    assert property (rd && a_r == serial_pkg::off_div_high |->
      hrdata[3:0] == div_r[11:8]) else $error("divisor readback wrong");
  chk_unmapped_zero:
    assert property (rd && a_r > serial_pkg::off_div_high |->
      hrdata == serial_pkg::bus_unmapped) else $error("unmapped not zero");
  chk_pin_enable:
    assert property ($stable(fmt_r) && $stable(ctl_r) |->
      transfer_clock_pin_oe == (fmt_r[6] & ctl_r[4]))
      else $error("pin enable wrong");
  chk_bit_normal:
    assert property ($fell(txd) && a0 && !ctl_r[2] |->
      !txd [*8] ##1 !txd [*8]) else $error("bit under 16 clocks");
  chk_bit_double:
    assert property ($fell(txd) && a0 && ctl_r[2] |-> !txd [*8])
      else $error("bit under 8 clocks");
  chk_txd_idle:
    assert property ($stable(ctl_r) && !ctl_r[1] |-> txd)
      else $error("txd not idle high");
endmodule
bind serial_port serial_port_monitor mon (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .txd,
  .transfer_clock_pin_oe);

//--- testbench/serial_partner.sv
/*
  remote serial transceiver: sends frames on rxd, captures from txd.
  assumes the bench calls its tasks with bit length in clocks.
*/
`timescale 1ns/10ps
module serial_partner (
  input wire logic hclk,
  input wire logic txd,
  output logic rxd,
  output logic timed_out
);
  initial
  begin
    rxd = 1'b1;
    timed_out = 1'b0;
  end
  // start, bits lsb first, then idle high
  task automatic send(input logic [11:0] f, input int nb, input int bc);
    for (int i = -1; i < nb; i++)
    begin
      rxd <= (i < 0) ? 1'b0 : f[i];
      repeat (bc) @(posedge hclk);
    end
    rxd <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic recv(input int nb, input int bc, output logic [11:0] f);
    int n;
    n = 0;
    f = 12'h000;
    while (txd && n < 4000)
    begin
      @(posedge hclk);
      n++;
    end
    timed_out = txd;
    repeat (bc / 2) @(posedge hclk);
    for (int i = 0; i < nb; i++)
    begin
      repeat (bc) @(posedge hclk);
      f[i] = txd;
    end
  endtask
endmodule

//--- testbench/tb_usart_clock_and_frame_format.sv
/*
  testbench for serial_port: all frame formats both ways, frame error,
  receive fifo depth, master pin. assumes serial_partner on the line.
*/
`timescale 1ns/10ps
module tb_usart_clock_and_frame_format;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic rxd;
  logic txd;
  logic ck_oe;
  logic ck_in;
  logic ck_out;
  logic ck_v;
  logic p_to;
  logic [31:0] seed;
  logic [31:0] r;
  logic [31:0] sr;
  logic [2:0] sz;
  logic [1:0] p;
  logic st;
  logic dbl;
  logic [8:0] d;
  logic [11:0] got;
  int c, n, nb, bc, dv, fails, tests_run;
  serial_port uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .rxd, .txd, .transfer_clock_pin_in(ck_in),
    .transfer_clock_pin_out(ck_out), .transfer_clock_pin_oe(ck_oe));
  serial_partner peer (.hclk, .txd, .rxd, .timed_out(p_to));
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [11:0] frame(logic [8:0] v);
    logic [11:0] m;
    m = (12'h001 << n) - 12'h001;
    frame = ({3'h0, v} & m) | ~((m << p[1]) | m);
    frame = frame | ({11'h0, p[1] & (^({3'h0, v} & m) ^ p[0])} << n);
  endfunction
  task automatic give_verdict();
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(logic ok, string what);
    tests_run++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && k < 50)
    begin
      @(posedge hclk);
      k++;
    end
    if (hreadyout !== 1'b1)
    begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic bus(logic [7:0] a, logic w, logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    wait_ready();
    r = hrdata;
  endtask
  task automatic rx_one(logic [11:0] f, logic fe);
    peer.send(f, nb, bc);
    repeat (bc) @(posedge hclk);
    bus(serial_pkg::off_status, 1'b0, 32'h0);
    sr = r;
    check(sr[0] & (sr[3] == fe) & ~sr[4] & ~sr[6], "rx status");
    bus(serial_pkg::off_data, 1'b0, 32'h0);
  endtask
  initial
  begin
    repeat (100000) @(posedge hclk);
    fails++;
    give_verdict();
  end
  initial
  begin
    seed = 32'h414d7a0e;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, ck_in} = '0;
    fails = 0;
    tests_run = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(serial_pkg::off_format, 1'b0, 32'h0);
    check(r[7:0] === serial_pkg::format_reset, "format reset");
    bus(8'h40, 1'b1, 32'hffffffff);
    bus(8'h40, 1'b0, 32'h0);
    check(r === serial_pkg::bus_unmapped, "unmapped read");
    for (c = 0; c < 30; c++)
    begin
      sz = (c % 5 == 4) ? serial_pkg::size_nine : 3'(c % 5);
      n = (c % 5 == 4) ? 9 : 5 + c % 5;
      p = (c / 5 % 3 == 0) ? serial_pkg::par_off : 2'(c / 5 % 3 + 1);
      st = c >= 15;
      dbl = c[0];
      dv = int'(rnd() & 32'h1);
      bc = (dbl ? 8 : 16) * (dv + 1);
      nb = n + int'(p[1]) + 1 + int'(st);
      bus(serial_pkg::off_div_high, 1'b1, 32'h0);
      bus(serial_pkg::off_div_low, 1'b1, 32'(dv));
      bus(serial_pkg::off_format, 1'b1, {26'h0, st, p, sz});
      d = 9'(rnd());
      bus(serial_pkg::off_ctrl, 1'b1, {28'h0, d[8], dbl, 2'h3});
      bus(serial_pkg::off_data, 1'b1, rnd() & 32'hfffffe00 | d);
      peer.recv(nb, bc, got);
      if (p_to)
      begin
        fails++;
        give_verdict();
      end
      check(((got ^ frame(d)) & ((12'h1 << nb) - 1)) == 0, "tx");
      repeat (bc) @(posedge hclk);
      d = 9'(rnd());
      rx_one(frame(d), 1'b0);
      check(((r[8:0] ^ d) & ((9'h1 << n) - 1)) == 0, "rx data");
      check(n < 9 || sr[5] === d[8], "ninth status");
    end
    rx_one(frame(d) & ~(12'h1 << (n + 1)), 1'b1);
    peer.send(frame(d), nb - 1, bc); // next start takes stop two
    rx_one(frame(d), 1'b0);
    bus(serial_pkg::off_status, 1'b0, 32'h0);
    check(r[0] & ~r[3], "second frame status");
    bus(serial_pkg::off_data, 1'b0, 32'h0);
    check(r[8:0] === d, "second frame data");
    for (c = 0; c < 3; c++)
      peer.send(frame(9'(c + 5)), nb, bc);
    repeat (bc) @(posedge hclk);
    for (c = 0; c < 3; c++)
    begin
      bus(serial_pkg::off_data, 1'b0, 32'h0);
      check(r[8:0] === 9'(c + 5), "fifo order");
    end
    bus(serial_pkg::off_status, 1'b0, 32'h0);
    check(r[0] === 1'b0, "fifo not empty");
    bus(serial_pkg::off_ctrl, 1'b1, 32'h13);
    bus(serial_pkg::off_format, 1'b1, 32'h43);
    repeat (3) @(posedge hclk);
    check(ck_oe === 1'b1, "master pin off");
    ck_v = ck_out;
    repeat (dv + 1) @(posedge hclk);
    check(ck_out === ~ck_v, "master clock rate");
    bus(serial_pkg::off_ctrl, 1'b1, 32'h03); // slave
    bus(serial_pkg::off_data, 1'b1, 32'h55);
    repeat (4) @(posedge hclk);
    check(txd === 1'b0, "sync start bit");
    for (c = 0; c < 3; c++)
    begin
      ck_in <= ~ck_in; // eight clocks per pin period
      repeat (4) @(posedge hclk);
      check(txd === (c < 2), "slave clock edges");
    end
    give_verdict();
  end
endmodule
